// >>> src/ihc_defs.vh
// register map, field positions, reset values and timing counts of the
// two-wire host collision block; definitions only
`ifndef IHC_DEFS_VH
`define IHC_DEFS_VH

// register indices; byte address is four times the index
`define IHC_IDX_BUFFER      12'h18c
`define IHC_IDX_DIVIDER     12'h18d
`define IHC_IDX_CONTROL2    12'h191
`define IHC_IDX_STATUS      12'h192
`define IHC_ADR_W           12

// host_control2_reg fields
`define IHC_C2_START        0
`define IHC_C2_RESTART      1
`define IHC_C2_STOP         2

// status fields
`define IHC_ST_COLLISION    0
`define IHC_ST_DONE         1
`define IHC_ST_BUSY         2
`define IHC_ST_SDA          3
`define IHC_ST_SCL          4

// reset values
`define IHC_DIVIDER_RST     8'h00
`define IHC_CONTROL2_RST    3'h0

// baud clock edges for one byte when a buffer write starts the generator
`define IHC_SHIFT_EDGES     5'h10

// states
`define IHC_S_IDLE          4'h0
`define IHC_S_START1        4'h1
`define IHC_S_START2        4'h2
`define IHC_S_RS_REL        4'h3
`define IHC_S_RS_SCLHI      4'h4
`define IHC_S_RS_CNT1       4'h5
`define IHC_S_RS_CNT2       4'h6
`define IHC_S_SP_SDALO      4'h7
`define IHC_S_SP_SCLHI      4'h8
`define IHC_S_SP_CNT        4'h9
`define IHC_S_SP_CHK        4'ha
`define IHC_S_SHIFT         4'hb

`endif

// >>> src/ihc_host_collision.v
// two-wire host condition sequencer with bus collision detection, shared
// baud counter and data buffer, reached over a classic wishbone slave.
// assumes open-drain pads with external pull-ups and one 25 MHz clock.
`timescale 1ns/1ps
`default_nettype none
`include "ihc_defs.vh"

module ihc_host_collision #(
  parameter CNT_W = 9
) (
  input  wire        clock,
  input  wire        rst,
  input  wire        cyc_i,
  input  wire        stb_i,
  input  wire        we_i,
  input  wire [13:0] adr_i,
  input  wire [3:0]  sel_i,
  input  wire [31:0] dat_i,
  output reg  [31:0] dat_o,
  output reg         ack_o,
  input  wire        sdaIn,
  output reg         sdaOut,
  output reg         sdaOe,
  input  wire        sclIn,
  output reg         sclOut,
  output reg         sclOe
);

  // pin synchronisers; only the agreed level of stages two and three is used
  reg [2:0] sdaSync_q;
  reg [2:0] sclSync_q;
  reg       sdaLvl_q;
  reg       sclLvl_q;

  always @(posedge clock) begin
    if (rst) begin
      sdaSync_q <= 3'h7;
      sclSync_q <= 3'h7;
      sdaLvl_q  <= 1'b1;
      sclLvl_q  <= 1'b1;
    end else begin
      sdaSync_q <= {sdaSync_q[1:0], sdaIn};
      sclSync_q <= {sclSync_q[1:0], sclIn};
      if (sdaSync_q[1] == sdaSync_q[2]) begin
        sdaLvl_q <= sdaSync_q[2];
      end
      if (sclSync_q[1] == sclSync_q[2]) begin
        sclLvl_q <= sclSync_q[2];
      end
    end
  end

  // registers
  reg [7:0]  buffer_q;
  reg [7:0]  divider_q;
  reg [2:0]  control2_q;
  reg        collision_q;
  reg        done_q;
  reg [3:0]  state_q;
  reg [CNT_W-1:0] baud_q;
  reg        baudRun_q;
  reg [4:0]  edges_q;

  // bus decode
  wire        req      = cyc_i & stb_i & ~ack_o;
  wire [11:0] regIdx   = adr_i[13:2];
  wire        wrLow    = req & we_i & sel_i[0];
  wire        hitBuf   = (regIdx == `IHC_IDX_BUFFER);
  wire        hitDiv   = (regIdx == `IHC_IDX_DIVIDER);
  wire        hitCtl   = (regIdx == `IHC_IDX_CONTROL2);
  wire        hitSt    = (regIdx == `IHC_IDX_STATUS);
  wire        bufWrite = wrLow & hitBuf;
  wire        ctlWrite = wrLow & hitCtl;
  wire        stWrite  = wrLow & hitSt;

  // half period of 2(n+1) cycles, two reloads per clock-line period
  wire [CNT_W-1:0] reloadVal = {divider_q, 1'b1};
  wire             expire    = baudRun_q & (baud_q == {CNT_W{1'b0}});

  always @(posedge clock) begin
    if (bufWrite) begin
      buffer_q <= dat_i[7:0];
    end
  end

  // wishbone slave: one-cycle answer, unmapped reads return zero
  always @(posedge clock) begin
    if (rst) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= req;
      dat_o <= 32'h0000_0000;
      if (req & ~we_i) begin
        if (hitBuf) begin
          dat_o[7:0] <= buffer_q;
        end else if (hitDiv) begin
          dat_o[7:0] <= divider_q;
        end else if (hitCtl) begin
          dat_o[2:0] <= control2_q;
        end else if (hitSt) begin
          dat_o[`IHC_ST_COLLISION] <= collision_q;
          dat_o[`IHC_ST_DONE]      <= done_q;
          dat_o[`IHC_ST_BUSY]      <= (state_q != `IHC_S_IDLE);
          dat_o[`IHC_ST_SDA]       <= sdaLvl_q;
          dat_o[`IHC_ST_SCL]       <= sclLvl_q;
        end
      end
    end
  end

  always @(posedge clock) begin
    if (rst) begin
      divider_q <= `IHC_DIVIDER_RST;
    end else if (wrLow & hitDiv) begin
      divider_q <= dat_i[7:0];
    end
  end

  // sequencer events
  reg       setCollision;
  reg       setDone;
  reg       clrCtl;
  reg [3:0] state_d;
  reg       sdaOe_d;
  reg       sclOe_d;
  reg       load;
  reg       stopCnt;

  always @* begin
    state_d      = state_q;
    sdaOe_d      = sdaOe;
    sclOe_d      = sclOe;
    setCollision = 1'b0;
    setDone      = 1'b0;
    clrCtl       = 1'b0;
    load         = 1'b0;
    stopCnt      = 1'b0;
    case (state_q)
      `IHC_S_IDLE: begin
        if (control2_q[`IHC_C2_START]) begin
          if (~sdaLvl_q | ~sclLvl_q) begin
            setCollision = 1'b1;
          end else begin
            sdaOe_d = 1'b0;
            sclOe_d = 1'b0;
            load    = 1'b1;
            state_d = `IHC_S_START1;
          end
        end else if (control2_q[`IHC_C2_RESTART]) begin
          sdaOe_d = 1'b0;
          load    = 1'b1;
          state_d = `IHC_S_RS_REL;
        end else if (control2_q[`IHC_C2_STOP]) begin
          sdaOe_d = 1'b1;
          state_d = `IHC_S_SP_SDALO;
        end else if (bufWrite) begin
          load    = 1'b1;
          state_d = `IHC_S_SHIFT;
        end
      end
      `IHC_S_START1: begin
        if (~sdaLvl_q) begin
          sdaOe_d = 1'b1;
          load    = 1'b1;
          state_d = `IHC_S_START2;
        end else if (~sclLvl_q) begin
          setCollision = 1'b1;
        end else if (expire) begin
          sdaOe_d = 1'b1;
          load    = 1'b1;
          state_d = `IHC_S_START2;
        end
      end
      `IHC_S_START2: begin
        if (expire) begin
          sclOe_d = 1'b1;
          setDone = 1'b1;
        end
      end
      `IHC_S_RS_REL: begin
        if (expire) begin
          sclOe_d = 1'b0;
          stopCnt = 1'b1;
          state_d = `IHC_S_RS_SCLHI;
        end
      end
      `IHC_S_RS_SCLHI: begin
        if (sclLvl_q) begin
          if (~sdaLvl_q) begin
            setCollision = 1'b1;
          end else begin
            load    = 1'b1;
            state_d = `IHC_S_RS_CNT1;
          end
        end
      end
      `IHC_S_RS_CNT1: begin
        if (~sclLvl_q) begin
          setCollision = 1'b1;
        end else if (expire) begin
          // data pull and reload; a falling data line is no collision
          sdaOe_d = 1'b1;
          load    = 1'b1;
          state_d = `IHC_S_RS_CNT2;
        end
      end
      `IHC_S_RS_CNT2: begin
        // clock pulled regardless of its level
        if (expire) begin
          sclOe_d = 1'b1;
          setDone = 1'b1;
        end
      end
      `IHC_S_SP_SDALO: begin
        if (~sdaLvl_q) begin
          sclOe_d = 1'b0;
          state_d = `IHC_S_SP_SCLHI;
        end
      end
      `IHC_S_SP_SCLHI: begin
        if (sclLvl_q) begin
          load    = 1'b1;
          state_d = `IHC_S_SP_CNT;
        end
      end
      `IHC_S_SP_CNT: begin
        if (~sclLvl_q) begin
          setCollision = 1'b1;
        end else if (expire) begin
          sdaOe_d = 1'b0;
          load    = 1'b1;
          state_d = `IHC_S_SP_CHK;
        end
      end
      `IHC_S_SP_CHK: begin
        // sample data one half period after release, past the synchroniser
        if (expire) begin
          if (~sdaLvl_q) begin
            setCollision = 1'b1;
          end else begin
            setDone = 1'b1;
          end
        end
      end
      `IHC_S_SHIFT: begin
        if (expire) begin
          sclOe_d = ~sclOe;
          if (edges_q == `IHC_SHIFT_EDGES - 5'h01) begin
            // stop counting, clock keeps last level
            stopCnt = 1'b1;
            state_d = `IHC_S_IDLE;
          end else begin
            load = 1'b1;
          end
        end
      end
      default: begin
        state_d = `IHC_S_IDLE;
        stopCnt = 1'b1;
      end
    endcase
    if (setCollision) begin
      // release both lines and clear the condition bits
      sdaOe_d = 1'b0;
      sclOe_d = 1'b0;
      clrCtl  = 1'b1;
      stopCnt = 1'b1;
      state_d = `IHC_S_IDLE;
    end
    if (setDone) begin
      // counter stops when the condition completes
      clrCtl  = 1'b1;
      stopCnt = 1'b1;
      state_d = `IHC_S_IDLE;
    end
  end

  // baud counter, reloaded from the divider
  always @(posedge clock) begin
    if (rst) begin
      baud_q    <= {CNT_W{1'b0}};
      baudRun_q <= 1'b0;
    end else if (load) begin
      baud_q    <= reloadVal;
      baudRun_q <= 1'b1;
    end else if (stopCnt) begin
      baudRun_q <= 1'b0;
    end else if (baudRun_q & ~expire) begin
      baud_q <= baud_q - {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge clock) begin
    if (rst) begin
      edges_q <= 5'h00;
    end else if (state_q != `IHC_S_SHIFT) begin
      edges_q <= 5'h00;
    end else if (expire) begin
      edges_q <= edges_q + 5'h01;
    end
  end

  // control bits: completion or collision clears; a write while busy is dropped
  always @(posedge clock) begin
    if (rst) begin
      control2_q <= `IHC_CONTROL2_RST;
    end else if (clrCtl) begin
      control2_q <= `IHC_CONTROL2_RST;
    end else if (ctlWrite & (state_q == `IHC_S_IDLE)) begin
      control2_q <= dat_i[2:0];
    end
  end

  // sticky flags: write one clears, a same-cycle set wins
  always @(posedge clock) begin
    if (rst) begin
      collision_q <= 1'b0;
      done_q      <= 1'b0;
    end else begin
      if (setCollision) begin
        collision_q <= 1'b1;
      end else if (stWrite & dat_i[`IHC_ST_COLLISION]) begin
        collision_q <= 1'b0;
      end
      if (setDone) begin
        done_q <= 1'b1;
      end else if (stWrite & dat_i[`IHC_ST_DONE]) begin
        done_q <= 1'b0;
      end
    end
  end

  // pads only ever pull low or float
  always @(posedge clock) begin
    if (rst) begin
      state_q <= `IHC_S_IDLE;
      sdaOe   <= 1'b0;
      sclOe   <= 1'b0;
      sdaOut  <= 1'b0;
      sclOut  <= 1'b0;
    end else begin
      state_q <= state_d;
      sdaOe   <= sdaOe_d;
      sclOe   <= sclOe_d;
      sdaOut  <= 1'b0;
      sclOut  <= 1'b0;
    end
  end

endmodule // ihc_host_collision
`default_nettype wire

// >>> bench/ihc_bus_model.sv
// open-drain two-wire bus with pull-ups and a second host on it
// assumes the block pulls a line low while its enable is high
`timescale 1ns/1ps
`default_nettype none
module ihc_bus_model (
  input  wire logic sdaOe,
  input  wire logic sclOe,
  input  wire logic sdaHold,
  input  wire logic sclHold,
  output var  logic sdaIn,
  output var  logic sclIn
);
  // wired-and: any puller wins, the pull-up gives the high level
  assign sdaIn = ~(sdaOe | sdaHold);
  assign sclIn = ~(sclOe | sclHold);
endmodule // ihc_bus_model
`default_nettype wire

// >>> bench/ihc_checker.sv
// concurrent checks on the ports of the host collision block
// assumes a classic wishbone master and the wired-and bus model
`timescale 1ns/1ps
`default_nettype none
`include "ihc_defs.vh"
module ihc_checker (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [13:0] adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic        sdaIn,
  input wire logic        sdaOut,
  input wire logic        sdaOe,
  input wire logic        sclIn,
  input wire logic        sclOut,
  input wire logic        sclOe
);
  wire reqTaken = cyc_i & stb_i & ~ack_o;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // start asked while another party already holds data low
  sequence sBlocked;
    (sclIn && !sdaIn)[*4] ##0 (reqTaken && we_i && sel_i[0] && dat_i[0]
      && adr_i[13:2] == `IHC_IDX_CONTROL2);
  endsequence
  sequence sSdaPulled;
    $rose(sdaOe) && !sclOe;
  endsequence
  a_only_pull_low: assert property (!sdaOut && !sclOut)
    else $error("line driven high");
  a_ack_follows_req: assert property (reqTaken |=> ack_o)
    else $error("request not answered");
  a_ack_single_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  a_unmapped_reads_zero: assert property (reqTaken && !we_i
    && adr_i[13:2] == 12'h000 |=> dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_start_busy_abort: assert property (sBlocked |=> (!sdaOe && !sclOe)[*8])
    else $error("start not abandoned");
  a_scl_after_sda: assert property (sSdaPulled |=> !sclOe[*8])
    else $error("clock pulled before count");
  a_scl_low_hold: assert property ($rose(sclOe) |=> sclOe[*8])
    else $error("clock low phase too short");
  a_scl_high_hold: assert property ($fell(sclOe) |=> !sclOe[*8])
    else $error("clock high phase too short");
endmodule // ihc_checker
bind ihc_host_collision ihc_checker u_chk (.clock(clock), .rst(rst), .cyc_i(cyc_i),
  .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
  .dat_o(dat_o), .ack_o(ack_o), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
  .sclIn(sclIn), .sclOut(sclOut), .sclOe(sclOe));
`default_nettype wire

// >>> bench/ihc_host_collision_bench.sv
// self-checking bench for the host collision block
// assumes the wired-and bus model and the bound checker
`timescale 1ns/1ps
`default_nettype none
`include "ihc_defs.vh"
module ihc_host_collision_bench;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [13:0] adr = 14'h0;
  logic [31:0] dat = 32'h0;
  logic        sdaHold = 1'b0;
  logic        sclHold = 1'b0;
  logic [31:0] rd;
  wire  [31:0] datO;
  wire         ackO, sdaIn, sclIn, sdaOut, sdaOe, sclOut, sclOe;
  int          err_total = 0;
  int          check_count = 0;
  always #20 clock = ~clock;
  ihc_host_collision dut (.clock(clock), .rst(rst), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(4'hf), .dat_i(dat), .dat_o(datO),
    .ack_o(ackO), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .sclIn(sclIn), .sclOut(sclOut), .sclOe(sclOe));
  ihc_bus_model bus (.sdaOe(sdaOe), .sclOe(sclOe), .sdaHold(sdaHold),
    .sclHold(sclHold), .sdaIn(sdaIn), .sclIn(sclIn));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [11:0] idx, input logic [31:0] d);
    int n;
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    dat <= d;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (ackO !== 1'b1 && n < 20);
    rd = datO;
    cyc <= 1'b0;
    stb <= 1'b0;
    chk("ack", 32'h1, {31'h0, ackO});
  endtask
  task automatic wbRd(input logic [11:0] idx, input logic [31:0] e, input string nm);
    wb(1'b0, idx, 32'h0);
    chk(nm, e, rd);
  endtask
  task automatic hold(input logic a, input logic b);
    @(posedge clock);
    sdaHold <= a;
    sclHold <= b;
    repeat (5) @(posedge clock);
  endtask
  // polls for done or collision, then clears both flags
  task automatic finish(input logic coll, input string nm);
    int n;
    n = 0;
    do begin
      wb(1'b0, `IHC_IDX_STATUS, 32'h0);
      n++;
    end while (rd[1:0] === 2'b00 && n < 100);
    // exactly one of collision or done must be up, so a hang cannot pass
    chk(nm, coll ? 32'h1 : 32'h2, {30'h0, rd[1:0]});
    wb(1'b1, `IHC_IDX_STATUS, 32'h3);
    wbRd(`IHC_IDX_CONTROL2, 32'h0, "control2");
  endtask
  task automatic cond(input logic [2:0] c);
    wb(1'b1, `IHC_IDX_CONTROL2, {29'h0, c});
  endtask
  task automatic tRegs;
    int n;
    wbRd(`IHC_IDX_DIVIDER, 32'h0, "divider reset");
    wb(1'b1, `IHC_IDX_DIVIDER, 32'h8);
    wbRd(`IHC_IDX_DIVIDER, 32'h8, "divider");
    wb(1'b1, `IHC_IDX_BUFFER, 32'ha5);
    @(posedge clock iff sclOe);
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (sclOe && n < 100);
    chk("half period", 32'h12, n);
    wbRd(`IHC_IDX_BUFFER, 32'ha5, "buffer");
    wb(1'b0, `IHC_IDX_STATUS, 32'h0);
    chk("busy", 32'h1, {31'h0, rd[2]});
    wbRd(12'h000, 32'h0, "unmapped");
    n = 0;
    do begin
      wb(1'b0, `IHC_IDX_STATUS, 32'h0);
      n++;
    end while (rd[2] !== 1'b0 && n < 200);
    chk("busy end", 32'h0, {31'h0, rd[2]});
    chk("clock level", 32'h0, {31'h0, sclOe});
    wb(1'b1, `IHC_IDX_STATUS, 32'h3);
  endtask
  task automatic tStartStop;
    cond(3'h1);
    finish(1'b0, "start");
    chk("lines", 32'h3, {30'h0, sdaOe, sclOe});
    cond(3'h4);
    finish(1'b0, "stop");
    chk("lines", 32'h0, {30'h0, sdaOe, sclOe});
  endtask
  task automatic tStartBusy;
    hold(1'b1, 1'b0);
    wb(1'b0, `IHC_IDX_STATUS, 32'h0);
    chk("sda level", 32'h0, {31'h0, rd[`IHC_ST_SDA]});
    chk("scl level", 32'h1, {31'h0, rd[`IHC_ST_SCL]});
    cond(3'h1);
    finish(1'b1, "start sda low");
    chk("lines", 32'h0, {30'h0, sdaOe, sclOe});
    hold(1'b0, 1'b0);
  endtask
  task automatic tStartScl;
    cond(3'h1);
    hold(1'b0, 1'b1);
    finish(1'b1, "start scl low");
    hold(1'b0, 1'b0);
  endtask
  task automatic tRestart;
    cond(3'h1);
    finish(1'b0, "start");
    cond(3'h2);
    finish(1'b0, "restart");
    chk("lines", 32'h3, {30'h0, sdaOe, sclOe});
    cond(3'h2);
    hold(1'b1, 1'b0);
    finish(1'b1, "restart sda low");
    chk("lines", 32'h0, {30'h0, sdaOe, sclOe});
    hold(1'b0, 1'b0);
    cond(3'h1);
    finish(1'b0, "start");
    cond(3'h2);
    // land the clock pull inside the third restart phase
    repeat (25) @(posedge clock);
    hold(1'b0, 1'b1);
    finish(1'b1, "restart scl low");
    chk("lines", 32'h0, {30'h0, sdaOe, sclOe});
    hold(1'b0, 1'b0);
  endtask
  task automatic tStopCol;
    cond(3'h1);
    finish(1'b0, "start");
    hold(1'b1, 1'b0);
    cond(3'h4);
    finish(1'b1, "stop sda low");
    hold(1'b0, 1'b0);
    cond(3'h1);
    finish(1'b0, "start");
    cond(3'h4);
    // wait until the released clock is seen high and the count runs
    repeat (8) @(posedge clock);
    hold(1'b0, 1'b1);
    finish(1'b1, "stop scl low");
    chk("lines", 32'h0, {30'h0, sdaOe, sclOe});
    hold(1'b0, 1'b0);
  endtask
  task automatic tStartEarly;
    cond(3'h1);
    hold(1'b1, 1'b0);
    @(posedge clock);
    chk("sda early", 32'h1, {31'h0, sdaOe});
    finish(1'b0, "start sda early");
    chk("lines", 32'h3, {30'h0, sdaOe, sclOe});
    hold(1'b0, 1'b0);
    cond(3'h4);
    finish(1'b0, "stop");
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    tRegs;
    tStartStop;
    tStartBusy;
    tStartScl;
    tRestart;
    tStopCol;
    tStartEarly;
    stop_test;
  end
  // about thirty times the expected run
  initial begin
    #(40 * 30000);
    err_total++;
    stop_test;
  end
endmodule // ihc_host_collision_bench
`default_nettype wire
